// *** pkg/hint_unit_pkg.sv ***
// Purpose: Shared constants and types for the system hint unit
// Assumes: Register bus is classic Wishbone, 32-bit data
// Notes: Status word layout follows the processor's flag positions

package hint_unit_pkg;

  // Instruction class presented by the decoder
  typedef enum logic [2:0] {
    OP_NO_OPERATION_HINT,
    OP_SEND_EVENT_HINT,
    OP_SUPERVISOR_CALL,
    OP_WAIT_FOR_EVENT,
    OP_WAIT_FOR_INTERRUPT,
    OP_MOVE_TO_SPECIAL_REG,
    OP_MOVE_FROM_SPECIAL_REG
  } hint_op_t;

  // Special register selector
  typedef enum logic [3:0] {
    SEL_APPLICATION_STATUS_WORD,
    SEL_APP_INT_STATUS,
    SEL_APP_EXEC_STATUS,
    SEL_PROGRAM_STATUS_WORD,
    SEL_INT_STATUS,
    SEL_EXEC_STATUS,
    SEL_MAIN_STACK_PTR,
    SEL_PROCESS_STACK_PTR,
    SEL_PRIORITY_MASK,
    SEL_BASE_PRIORITY_MASK,
    SEL_RAISE_ONLY_PRIORITY_ALIAS,
    SEL_FAULT_MASK,
    SEL_CONTROL
  } spec_sel_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT_EVENT,
    ST_WAIT_INTERRUPT
  } run_state_t;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_CORE_STATE = 8'h0C;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h10;
  localparam logic [7:0] OFS_PRIORITY = 8'h14;

  // Config register fields
  localparam int CFG_WAKE_ON_PENDING_BIT = 0;
  localparam int CFG_DEBUG_ENABLE_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // Interrupt status bit positions
  localparam int IRQ_SVC_BIT = 0;
  localparam int IRQ_SEND_EVENT_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int IRQ_SUSPEND_BIT = 3;
  localparam int IRQ_WIDTH = 4;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // Core state register fields
  localparam int STATE_EVENT_BIT = 0;
  localparam int STATE_WAIT_EVENT_BIT = 1;
  localparam int STATE_WAIT_INT_BIT = 2;
  localparam int STATE_PRIV_MASK_BIT = 3;
  localparam int STATE_FAULT_MASK_BIT = 4;

  // Status word field masks
  localparam logic [31:0] FLAGS_MASK = 32'hF800_0000;
  localparam logic [31:0] EXEC_STATE_MASK = 32'h0700_FC00;
  localparam logic [31:0] INT_NUM_MASK = 32'h0000_01FF;
  localparam logic [31:0] STATUS_WORD_RESET = 32'h0100_0000;
  localparam logic [31:0] STACK_ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [7:0] BASE_PRIORITY_RESET = 8'h00;

endpackage : hint_unit_pkg

// *** src/system_hint_unit.sv ***
// Purpose: System hint and special register move unit of the core
// Assumes: Decoder, exception and debug logic share CORE_CLK_I
// Notes: Only the external event pin is synchronised
//
// Contract
// - Unprivileged reads reach only application status word; unprivileged writes set flags via all four status word selectors
// - Unprivileged writes keep unallocated, execution bits
// - Raise-only alias writes only nonzero, higher priority
// - Reading raise-only alias returns base mask
// - Status word move sets flags from source
// - No-operation hint has no effect
// - Send event pulses outward and sets event
// - Supervisor call raises exception, immediate ignored
// - Wait-for-event suspends when event register clear
// - Exception wakes only when unmasked, above priority
// - Pending exception wakes only with enable bit
// - Debug wakes if enabled; external events wake
// - Set event register is cleared, no suspend
// - Wait-for-interrupt wakes on any exception, debug
// - Hints never alter condition flags
// - Instructions execute only when condition passes
//
// The Wishbone slave port and the register addresses were decided locally.

`timescale 1ns/100ps

module system_hint_unit
  import hint_unit_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int PRIO_W = 8
)
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ_O,
  // Instruction issue
  input wire logic INSTR_VALID_I,
  input wire hint_unit_pkg::hint_op_t INSTR_OP_I,
  input wire hint_unit_pkg::spec_sel_t INSTR_SEL_I,
  input wire logic INSTR_COND_PASS_I,
  input wire logic PRIVILEGED_I,
  input wire logic [DATA_W-1:0] SOURCE_REGISTER_I,
  output logic INSTR_READY_O,
  output logic [DATA_W-1:0] READ_DATA_O,
  output logic READ_VALID_O,
  // Exception controller
  input wire logic EXC_REQ_I,
  input wire logic [PRIO_W-1:0] EXC_PRIO_I,
  input wire logic [PRIO_W-1:0] EXEC_PRIO_I,
  input wire logic EXC_PENDING_I,
  output logic SVC_REQ_O,
  // Debug and events
  input wire logic DEBUG_REQ_I,
  input wire logic EXT_EVENT_I,
  output logic SEND_EVENT_O,
  // Architectural state
  output logic [DATA_W-1:0] STATUS_WORD_O,
  output logic [PRIO_W-1:0] BASE_PRIORITY_O,
  output logic PRIORITY_MASK_O,
  output logic FAULT_MASK_O,
  output logic [1:0] CONTROL_O,
  output logic SLEEPING_O
);

  import hint_unit_pkg::*;

  run_state_t state;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] main_sp;
  logic [DATA_W-1:0] process_sp;
  logic [PRIO_W-1:0] base_priority_mask;
  logic priority_mask;
  logic fault_mask;
  logic [1:0] control;
  logic event_reg;
  logic [1:0] cfg;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_event;
  logic fire;
  logic do_move_to;
  logic wake_event;
  logic wake_int;
  logic exc_unblocked;
  logic alias_update;
  logic [DATA_W-1:0] status_wmask;
  logic [DATA_W-1:0] next_status_word;
  logic [DATA_W-1:0] spec_read;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic bus_req;
  logic bus_wr;
  logic [31:0] wr_mask;

  // External event pin synchroniser and edge detect
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_meta <= EXT_EVENT_I;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_event = ext_sync & ~ext_prev;

  // Issue handshake: stalls while suspended
  assign INSTR_READY_O = (state == ST_RUN);
  assign fire = INSTR_VALID_I & INSTR_READY_O & INSTR_COND_PASS_I;
  assign do_move_to = fire & (INSTR_OP_I == OP_MOVE_TO_SPECIAL_REG);

  // Masked exception check against mask registers and priority
  always_comb
  begin
    exc_unblocked = EXC_REQ_I & ~priority_mask & ~fault_mask;
    if (EXC_PRIO_I >= EXEC_PRIO_I)
    begin
      exc_unblocked = 1'b0;
    end
    if ((base_priority_mask != '0) && (EXC_PRIO_I >= base_priority_mask))
    begin
      exc_unblocked = 1'b0;
    end
  end

  assign wake_event = exc_unblocked
    | (EXC_PENDING_I & cfg[CFG_WAKE_ON_PENDING_BIT])
    | (DEBUG_REQ_I & cfg[CFG_DEBUG_ENABLE_BIT])
    | ext_event;
  assign wake_int = EXC_REQ_I | DEBUG_REQ_I;

  // Suspension state machine
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state <= ST_RUN;
    end
    else
    begin
      unique case (state)
        ST_RUN:
        begin
          if (fire && (INSTR_OP_I == OP_WAIT_FOR_EVENT) && !event_reg)
          begin
            state <= ST_WAIT_EVENT;
          end
          else if (fire && (INSTR_OP_I == OP_WAIT_FOR_INTERRUPT))
          begin
            state <= ST_WAIT_INTERRUPT;
          end
        end
        ST_WAIT_EVENT:
        begin
          // Event caught on the suspend edge must not be lost
          if (wake_event || event_reg)
          begin
            state <= ST_RUN;
          end
        end
        ST_WAIT_INTERRUPT:
        begin
          if (wake_int)
          begin
            state <= ST_RUN;
          end
        end
        default:
        begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  assign SLEEPING_O = (state != ST_RUN);

  // Local event register; a new event wins over consumption
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      event_reg <= 1'b0;
    end
    else if (fire && (INSTR_OP_I == OP_SEND_EVENT_HINT))
    begin
      event_reg <= 1'b1;
    end
    else if (ext_event && (state == ST_RUN))
    begin
      event_reg <= 1'b1;
    end
    else if (fire && (INSTR_OP_I == OP_WAIT_FOR_EVENT))
    begin
      event_reg <= 1'b0;
    end
  end

  // Outgoing pulses to other processors and exception controller
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      SEND_EVENT_O <= 1'b0;
      SVC_REQ_O <= 1'b0;
    end
    else
    begin
      SEND_EVENT_O <= fire & (INSTR_OP_I == OP_SEND_EVENT_HINT);
      // Call number stays in the opcode for the handler
      SVC_REQ_O <= fire & (INSTR_OP_I == OP_SUPERVISOR_CALL);
    end
  end

  // Writable status word bits by target and privilege
  always_comb
  begin
    status_wmask = '0;
    unique case (INSTR_SEL_I)
      SEL_APPLICATION_STATUS_WORD, SEL_APP_INT_STATUS,
      SEL_APP_EXEC_STATUS, SEL_PROGRAM_STATUS_WORD:
      begin
        status_wmask = FLAGS_MASK;
      end
      default:
      begin
        status_wmask = '0;
      end
    endcase
    if (PRIVILEGED_I && (INSTR_SEL_I == SEL_PROGRAM_STATUS_WORD))
    begin
      status_wmask = FLAGS_MASK | EXEC_STATE_MASK;
    end
  end

  // Unallocated bits never change; unprivileged keeps exec state
  assign next_status_word = (status_word & ~status_wmask)
    | (SOURCE_REGISTER_I & status_wmask);

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      status_word <= STATUS_WORD_RESET;
    end
    else if (do_move_to)
    begin
      status_word <= next_status_word;
    end
  end

  // Raise-only alias gate
  assign alias_update = (SOURCE_REGISTER_I[PRIO_W-1:0] != '0)
    && ((base_priority_mask == '0)
    || (SOURCE_REGISTER_I[PRIO_W-1:0] < base_priority_mask));

  // Privileged-only special registers
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      base_priority_mask <= BASE_PRIORITY_RESET;
      priority_mask <= 1'b0;
      fault_mask <= 1'b0;
      control <= 2'h0;
      main_sp <= '0;
      process_sp <= '0;
    end
    else if (do_move_to && PRIVILEGED_I)
    begin
      unique case (INSTR_SEL_I)
        SEL_BASE_PRIORITY_MASK:
        begin
          base_priority_mask <= SOURCE_REGISTER_I[PRIO_W-1:0];
        end
        SEL_RAISE_ONLY_PRIORITY_ALIAS:
        begin
          if (alias_update)
          begin
            base_priority_mask <= SOURCE_REGISTER_I[PRIO_W-1:0];
          end
        end
        SEL_PRIORITY_MASK:
        begin
          priority_mask <= SOURCE_REGISTER_I[0];
        end
        SEL_FAULT_MASK:
        begin
          fault_mask <= SOURCE_REGISTER_I[0];
        end
        SEL_CONTROL:
        begin
          control <= SOURCE_REGISTER_I[1:0];
        end
        SEL_MAIN_STACK_PTR:
        begin
          main_sp <= SOURCE_REGISTER_I & STACK_ALIGN_MASK;
        end
        SEL_PROCESS_STACK_PTR:
        begin
          process_sp <= SOURCE_REGISTER_I & STACK_ALIGN_MASK;
        end
        default:
        begin
          control <= control;
        end
      endcase
    end
  end

  // Read selection for move-from
  always_comb
  begin
    spec_read = '0;
    unique case (INSTR_SEL_I)
      SEL_APPLICATION_STATUS_WORD:
      begin
        spec_read = status_word & FLAGS_MASK;
      end
      SEL_APP_INT_STATUS:
      begin
        spec_read = status_word & (FLAGS_MASK | INT_NUM_MASK);
      end
      SEL_APP_EXEC_STATUS:
      begin
        spec_read = status_word & FLAGS_MASK;
      end
      SEL_PROGRAM_STATUS_WORD:
      begin
        spec_read = status_word & (FLAGS_MASK | INT_NUM_MASK);
      end
      SEL_INT_STATUS:
      begin
        spec_read = status_word & INT_NUM_MASK;
      end
      SEL_EXEC_STATUS:
      begin
        spec_read = '0;
      end
      SEL_MAIN_STACK_PTR:
      begin
        spec_read = main_sp;
      end
      SEL_PROCESS_STACK_PTR:
      begin
        spec_read = process_sp;
      end
      SEL_PRIORITY_MASK:
      begin
        spec_read = {{(DATA_W-1){1'b0}}, priority_mask};
      end
      SEL_BASE_PRIORITY_MASK, SEL_RAISE_ONLY_PRIORITY_ALIAS:
      begin
        spec_read = {{(DATA_W-PRIO_W){1'b0}}, base_priority_mask};
      end
      SEL_FAULT_MASK:
      begin
        spec_read = {{(DATA_W-1){1'b0}}, fault_mask};
      end
      SEL_CONTROL:
      begin
        spec_read = {{(DATA_W-2){1'b0}}, control};
      end
      default:
      begin
        spec_read = '0;
      end
    endcase
    if (!PRIVILEGED_I && (INSTR_SEL_I != SEL_APPLICATION_STATUS_WORD))
    begin
      spec_read = '0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      READ_DATA_O <= '0;
      READ_VALID_O <= 1'b0;
    end
    else
    begin
      READ_VALID_O <= fire & (INSTR_OP_I == OP_MOVE_FROM_SPECIAL_REG);
      if (fire && (INSTR_OP_I == OP_MOVE_FROM_SPECIAL_REG))
      begin
        READ_DATA_O <= spec_read;
      end
    end
  end

  // No-operation hint is accepted and retired with no effect
  // only the move-to path above touches flags

  assign STATUS_WORD_O = status_word;
  assign BASE_PRIORITY_O = base_priority_mask;
  assign PRIORITY_MASK_O = priority_mask;
  assign FAULT_MASK_O = fault_mask;
  assign CONTROL_O = control;

  // Wishbone slave: one-cycle answer, ack drops after
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign bus_wr = bus_req & WB_WE_I;
  assign wr_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
    {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      WB_ACK_O <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= bus_req;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cfg <= CFG_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end
    else if (bus_wr && WB_SEL_I[0])
    begin
      if (WB_ADR_I == OFS_CONFIG)
      begin
        cfg <= WB_DAT_I[1:0];
      end
      if (WB_ADR_I == OFS_IRQ_MASK)
      begin
        irq_mask <= WB_DAT_I[IRQ_WIDTH-1:0];
      end
    end
  end

  // Sticky events; set wins over write-one-to-clear
  assign irq_set = {
    (state == ST_RUN) & fire & ((INSTR_OP_I == OP_WAIT_FOR_EVENT & ~event_reg)
      | INSTR_OP_I == OP_WAIT_FOR_INTERRUPT),
    ((state == ST_WAIT_EVENT) & wake_event)
      | ((state == ST_WAIT_INTERRUPT) & wake_int),
    fire & (INSTR_OP_I == OP_SEND_EVENT_HINT),
    fire & (INSTR_OP_I == OP_SUPERVISOR_CALL)};

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      irq_status <= '0;
    end
    else
    begin
      if (bus_wr && WB_SEL_I[0] && (WB_ADR_I == OFS_IRQ_STATUS))
      begin
        irq_status <= (irq_status & ~WB_DAT_I[IRQ_WIDTH-1:0]) | irq_set;
      end
      else
      begin
        irq_status <= irq_status | irq_set;
      end
    end
  end

  assign IRQ_O = |(irq_status & irq_mask);

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      WB_DAT_O <= '0;
    end
    else if (bus_req && !WB_WE_I)
    begin
      unique case (WB_ADR_I)
        OFS_CONFIG:
        begin
          WB_DAT_O <= {30'h0, cfg};
        end
        OFS_IRQ_STATUS:
        begin
          WB_DAT_O <= {28'h0, irq_status};
        end
        OFS_IRQ_MASK:
        begin
          WB_DAT_O <= {28'h0, irq_mask};
        end
        OFS_CORE_STATE:
        begin
          WB_DAT_O <= {27'h0, fault_mask, priority_mask,
            state == ST_WAIT_INTERRUPT, state == ST_WAIT_EVENT, event_reg};
        end
        OFS_STATUS_WORD:
        begin
          WB_DAT_O <= status_word;
        end
        OFS_PRIORITY:
        begin
          WB_DAT_O <= {{(32-PRIO_W){1'b0}}, base_priority_mask};
        end
        default:
        begin
          WB_DAT_O <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule : system_hint_unit

// *** sim/hint_unit_chk_asserts.sv ***
// Purpose: Port checks for the system hint unit
// Assumes: One core clock domain, async active-low reset
// Notes: Bound onto every system_hint_unit instance
`timescale 1ns/100ps
module hint_unit_chk
  import hint_unit_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int PRIO_W = 8
)
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Register bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input logic WB_ACK_O,
  // Instruction issue
  input wire logic INSTR_VALID_I,
  input wire hint_unit_pkg::hint_op_t INSTR_OP_I,
  input wire hint_unit_pkg::spec_sel_t INSTR_SEL_I,
  input wire logic INSTR_COND_PASS_I,
  input wire logic PRIVILEGED_I,
  input wire logic [DATA_W-1:0] SOURCE_REGISTER_I,
  input logic INSTR_READY_O,
  // Wake sources and results
  input wire logic EXC_REQ_I,
  input wire logic DEBUG_REQ_I,
  input wire logic EXT_EVENT_I,
  input logic SVC_REQ_O,
  input logic SEND_EVENT_O,
  input logic [DATA_W-1:0] STATUS_WORD_O,
  input logic [PRIO_W-1:0] BASE_PRIORITY_O,
  input logic SLEEPING_O
);
  import hint_unit_pkg::*;
  logic ex;
  logic move_to_special_reg;
  logic wfe_wait;
  logic [PRIO_W-1:0] src;
  logic [PRIO_W-1:0] next_base;
  assign ex = INSTR_VALID_I && INSTR_READY_O && INSTR_COND_PASS_I;
  assign move_to_special_reg = ex && INSTR_OP_I == OP_MOVE_TO_SPECIAL_REG;
  assign src = SOURCE_REGISTER_I[PRIO_W-1:0];
  assign next_base = (src != '0 && (BASE_PRIORITY_O == '0 ||
    src < BASE_PRIORITY_O)) ? src : BASE_PRIORITY_O;
  // Last issued op was wait-for-event
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wfe_wait <= 1'b0;
    end
    else if (ex)
    begin
      wfe_wait <= (INSTR_OP_I == OP_WAIT_FOR_EVENT);
    end
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  ack_time_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus ack not one cycle after request");
  sleep_ready_a: assert property (
    INSTR_READY_O != SLEEPING_O)
    else $error("ready and sleeping disagree");
  no_priv_a: assert property (
    move_to_special_reg && !PRIVILEGED_I |=> $stable(BASE_PRIORITY_O))
    else $error("unprivileged move changed base priority");
  raise_only_a: assert property (
    move_to_special_reg && PRIVILEGED_I && INSTR_SEL_I == SEL_RAISE_ONLY_PRIORITY_ALIAS
    |=> BASE_PRIORITY_O == $past(next_base))
    else $error("raise-only write wrong");
  flags_set_a: assert property (
    move_to_special_reg && INSTR_SEL_I == SEL_APPLICATION_STATUS_WORD
    |=> (STATUS_WORD_O & FLAGS_MASK) == ($past(SOURCE_REGISTER_I) & FLAGS_MASK))
    else $error("flags not taken from source");
  sev_out_a: assert property (
    ex && INSTR_OP_I == OP_SEND_EVENT_HINT |=> SEND_EVENT_O)
    else $error("send event not signalled");
  svc_raise_a: assert property (
    ex && INSTR_OP_I == OP_SUPERVISOR_CALL |=> SVC_REQ_O)
    else $error("supervisor call not raised");
  ext_wake_a: assert property (
    SLEEPING_O && wfe_wait && $rose(EXT_EVENT_I) |-> ##[1:8] !SLEEPING_O)
    else $error("external event did not wake");
  wfi_sleep_a: assert property (
    ex && INSTR_OP_I == OP_WAIT_FOR_INTERRUPT && !EXC_REQ_I && !DEBUG_REQ_I
    |=> SLEEPING_O && !INSTR_READY_O)
    else $error("wait for interrupt did not suspend");
  flags_keep_a: assert property (
    ex && INSTR_OP_I != OP_MOVE_TO_SPECIAL_REG
    |=> $stable(STATUS_WORD_O & FLAGS_MASK))
    else $error("hint changed flags");
  cond_skip_a: assert property (
    INSTR_VALID_I && INSTR_READY_O && !INSTR_COND_PASS_I
    |=> !SVC_REQ_O && !SEND_EVENT_O && !SLEEPING_O && $stable(STATUS_WORD_O))
    else $error("failed condition still executed");
endmodule : hint_unit_chk

bind system_hint_unit hint_unit_chk #(.DATA_W(DATA_W), .PRIO_W(PRIO_W)) chk (.*);

// *** sim/exc_partner.sv ***
// Purpose: Exception, debug and event source model
// Assumes: Bench calls raise() for each wake stimulus
// Notes: Released exception priority line shows the inverse of the last value
`timescale 1ns/100ps
module exc_partner
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pulses from the hint unit
  input wire logic svc_req_i,
  input wire logic send_event_i,
  // Wake sources
  output logic exc_req_o,
  output logic [7:0] exc_prio_o,
  output logic [7:0] exec_prio_o,
  output logic exc_pending_o,
  output logic debug_req_o,
  output logic ext_event_o
);
  int svc_cnt;
  int sev_cnt;
  initial
  begin
    exc_req_o = 1'b0;
    exc_prio_o = 8'hFF;
    exec_prio_o = 8'h40;
    exc_pending_o = 1'b0;
    debug_req_o = 1'b0;
    ext_event_o = 1'b0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      svc_cnt <= 0;
      sev_cnt <= 0;
    end
    else
    begin
      svc_cnt <= svc_cnt + int'(svc_req_i);
      sev_cnt <= sev_cnt + int'(send_event_i);
    end
  end
  // Kind 0 exception, 1 pending, 2 debug, 3 event pin
  task automatic raise(input int kind, input logic [7:0] prio,
      input int hold);
    @(posedge clk_i);
    exc_prio_o <= prio;
    exc_req_o <= (kind == 0);
    exc_pending_o <= (kind == 1);
    debug_req_o <= (kind == 2);
    ext_event_o <= (kind == 3);
    repeat (hold) @(posedge clk_i);
    exc_req_o <= 1'b0;
    exc_pending_o <= 1'b0;
    debug_req_o <= 1'b0;
    ext_event_o <= 1'b0;
    exc_prio_o <= ~prio;
  endtask : raise
endmodule : exc_partner

// *** sim/system_hint_instruction_unit_tb.sv ***
// Purpose: Self-checking bench for the system hint unit
// Assumes: 250 MHz core clock, reset held 16 cycles
// Notes: Wake sources come from the partner model
`timescale 1ns/100ps
module system_hint_instruction_unit_tb;
  import hint_unit_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic valid = 1'b0;
  hint_op_t op = OP_NO_OPERATION_HINT;
  spec_sel_t spec = SEL_CONTROL;
  logic cond = 1'b0;
  logic priv = 1'b0;
  logic [31:0] src = 32'h0;
  logic [31:0] rdat, rd, sw;
  logic [7:0] eprio, xprio, bp;
  logic ack, irq, ready, rv, exc, pend, supervisor_call, dbg, ev, send_event_hint, slp;
  int error_cnt = 0;
  int compares = 0;
  localparam hint_op_t MTS = OP_MOVE_TO_SPECIAL_REG;
  always #2 clk = ~clk;
  system_hint_unit dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_O(irq), .INSTR_VALID_I(valid),
    .INSTR_OP_I(op), .INSTR_SEL_I(spec), .INSTR_COND_PASS_I(cond),
    .PRIVILEGED_I(priv), .SOURCE_REGISTER_I(src), .INSTR_READY_O(ready),
    .READ_DATA_O(rd), .READ_VALID_O(rv), .EXC_REQ_I(exc),
    .EXC_PRIO_I(eprio), .EXEC_PRIO_I(xprio), .EXC_PENDING_I(pend),
    .SVC_REQ_O(supervisor_call), .DEBUG_REQ_I(dbg), .EXT_EVENT_I(ev),
    .SEND_EVENT_O(send_event_hint), .STATUS_WORD_O(sw), .BASE_PRIORITY_O(bp),
    .PRIORITY_MASK_O(), .FAULT_MASK_O(), .CONTROL_O(), .SLEEPING_O(slp)
  );
  exc_partner far (
    .clk_i(clk), .rst_n_i(rst_n), .svc_req_i(supervisor_call), .send_event_i(send_event_hint),
    .exc_req_o(exc), .exc_prio_o(eprio), .exec_prio_o(xprio),
    .exc_pending_o(pend), .debug_req_o(dbg), .ext_event_o(ev)
  );
  task automatic finish_test();
    $display("TB: errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic ins(input hint_op_t o, input spec_sel_t s,
      input logic [31:0] v, input logic p, input logic c);
    @(posedge clk);
    valid <= 1'b1;
    op <= o;
    spec <= s;
    src <= v;
    priv <= p;
    cond <= c;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
  endtask : ins
  task automatic t_reset();
    logic [31:0] q;
    chk("status", STATUS_WORD_RESET, sw);
    chk("ready", 32'h1, 32'(ready));
    wb(1'b0, OFS_CORE_STATE, 32'h0, q);
    chk("event reg", 32'h0, 32'(q[STATE_EVENT_BIT]));
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'hFC, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask : t_reset
  task automatic t_msr();
    ins(MTS, SEL_APPLICATION_STATUS_WORD, 32'hA800_0000, 1'b1, 1'b1);
    chk("flags", 32'hA800_0000, sw & FLAGS_MASK);
    ins(MTS, SEL_PROGRAM_STATUS_WORD, 32'hFFFF_FFFF, 1'b0, 1'b1);
    chk("flags u", FLAGS_MASK, sw & FLAGS_MASK);
    chk("exec", STATUS_WORD_RESET, sw & EXEC_STATE_MASK);
    chk("spare", 32'h0, sw & ~(FLAGS_MASK | EXEC_STATE_MASK));
    ins(MTS, SEL_BASE_PRIORITY_MASK, 32'h30, 1'b0, 1'b1);
    chk("unpriv base", 32'h0, 32'(bp));
    ins(MTS, SEL_APPLICATION_STATUS_WORD, 32'h0, 1'b1, 1'b0);
    chk("cond fail", FLAGS_MASK, sw & FLAGS_MASK);
  endtask : t_msr
  task automatic t_base();
    logic [7:0] v [5] = '{8'h40, 8'h80, 8'h20, 8'h20, 8'h00};
    logic [7:0] e [5] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h20};
    foreach (v[i])
    begin
      ins(MTS, SEL_RAISE_ONLY_PRIORITY_ALIAS, 32'(v[i]), 1'b1, 1'b1);
      chk("raise", 32'(e[i]), 32'(bp));
    end
    ins(OP_MOVE_FROM_SPECIAL_REG, SEL_RAISE_ONLY_PRIORITY_ALIAS, 32'h0,
      1'b1, 1'b1);
    chk("alias read", 32'h20, rd);
    chk("read valid", 32'h1, 32'(rv));
    ins(MTS, SEL_BASE_PRIORITY_MASK, 32'h0, 1'b1, 1'b1);
    chk("base clear", 32'h0, 32'(bp));
  endtask : t_base
  task automatic t_hints();
    logic [31:0] s;
    logic [31:0] q;
    s = sw;
    ins(OP_NO_OPERATION_HINT, SEL_CONTROL, 32'h0, 1'b1, 1'b1);
    chk("nop", s, sw);
    ins(OP_SEND_EVENT_HINT, SEL_CONTROL, 32'h0, 1'b1, 1'b1);
    chk("sev out", 32'h1, 32'(send_event_hint));
    wb(1'b0, OFS_CORE_STATE, 32'h0, q);
    chk("event set", 32'h1, 32'(q[STATE_EVENT_BIT]));
    ins(OP_WAIT_FOR_EVENT, SEL_CONTROL, 32'h0, 1'b1, 1'b1);
    chk("no sleep", 32'h0, 32'(slp));
    wb(1'b0, OFS_CORE_STATE, 32'h0, q);
    chk("event clr", 32'h0, 32'(q[STATE_EVENT_BIT]));
    ins(OP_SUPERVISOR_CALL, SEL_CONTROL, 32'h0, 1'b1, 1'b1);
    chk("svc", 32'h1, 32'(supervisor_call));
    chk("flags kept", s, sw);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, q);
    chk("irq status", 32'h3, q);
    wb(1'b1, OFS_IRQ_MASK, 32'h1, q);
    chk("irq on", 32'h1, 32'(irq));
    wb(1'b1, OFS_IRQ_STATUS, 32'h1, q);
    chk("irq off", 32'h0, 32'(irq));
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, q);
    chk("w1c", 32'h2, q);
    chk("svc cnt", 32'h1, 32'(far.svc_cnt));
    chk("sev cnt", 32'h1, 32'(far.sev_cnt));
  endtask : t_hints
  task automatic sleep_case(input hint_op_t o, input int k,
      input logic [7:0] pr, input logic [31:0] cfg, input logic wk);
    logic [31:0] q;
    wb(1'b1, OFS_CONFIG, cfg, q);
    if (slp !== 1'b1)
      ins(o, SEL_CONTROL, 32'h0, 1'b1, 1'b1);
    chk("asleep", 32'h1, 32'(slp));
    far.raise(k, pr, (k == 3) ? 6 : 1);
    @(negedge clk);
    chk("woken", 32'(!wk), 32'(slp));
  endtask : sleep_case
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_msr();
    t_base();
    t_hints();
    sleep_case(OP_WAIT_FOR_EVENT, 0, 8'h80, 32'h0, 1'b0);
    sleep_case(OP_WAIT_FOR_EVENT, 0, 8'h10, 32'h0, 1'b1);
    sleep_case(OP_WAIT_FOR_EVENT, 1, 8'h10, 32'h0, 1'b0);
    sleep_case(OP_WAIT_FOR_EVENT, 1, 8'h10, 32'h1, 1'b1);
    sleep_case(OP_WAIT_FOR_EVENT, 2, 8'h10, 32'h0, 1'b0);
    sleep_case(OP_WAIT_FOR_EVENT, 2, 8'h10, 32'h2, 1'b1);
    sleep_case(OP_WAIT_FOR_EVENT, 3, 8'h10, 32'h0, 1'b1);
    sleep_case(OP_WAIT_FOR_INTERRUPT, 0, 8'h80, 32'h0, 1'b1);
    sleep_case(OP_WAIT_FOR_INTERRUPT, 3, 8'h10, 32'h0, 1'b0);
    sleep_case(OP_WAIT_FOR_INTERRUPT, 2, 8'h10, 32'h0, 1'b1);
    finish_test();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule : system_hint_instruction_unit_tb
